/* File: hbcd_chk.sv */
// Purpose: Port assertions for hbcd_top
// Assumes: One clock, async active-low reset
// Notes:   Stimulus holds configuration steady around each check
`timescale 1ns/100ps
`default_nettype none
module hbcd_chk (
	// Clock and resets
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	input wire logic        local_bus_reset_i,
	// Configuration and host pins
	input wire logic        local_mode_i,
	input wire logic [7:0]  rom_control_reg_i,
	input wire logic [7:0]  power_down_control_reg_i,
	input wire logic        mem_read_strobe_n_i,
	input wire logic        refresh_n_i,
	input wire logic        io_write_strobe_n_i,
	input wire logic        host_ready_in_n_i,
	input wire logic        cycle_start_i,
	input wire logic [23:0] mem_addr_i,
	input wire logic [15:0] io_addr_i,
	input wire logic [7:0]  io_wdata_i,
	// Results
	input wire logic        mem_access_o,
	input wire logic        refresh_start_o,
	input wire logic        refresh_tick_o,
	input wire logic        cycle_done_o,
	input wire logic        rom_enable_n_o,
	input wire logic        page_unlocked_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	// Expansion I/O write hits; past strobe high keeps one write one event
	wire exp_wr = !local_mode_i && !io_write_strobe_n_i;
	wire hit_pg = exp_wr && io_addr_i == 16'h46E8;
	wire rom_hit = mem_addr_i inside {[24'hC_0000:24'hC_7FFF]};
	refr_gate_a:
		assert property (!local_mode_i && !refresh_n_i |=> !mem_access_o)
		else $error("memory access during refresh");
	ref_start_a:
		assert property (!local_mode_i && $fell(refresh_n_i) |=> refresh_start_o)
		else $error("refresh start missing");
	rom_win_a:
		assert property (!local_mode_i && refresh_n_i && !mem_read_strobe_n_i &&
			rom_control_reg_i[0] && rom_hit |=> !rom_enable_n_o)
		else $error("ROM enable missing in window");
	unlock_a:
		assert property (exp_wr && io_addr_i == 16'hA875 && io_wdata_i == 8'hAC
			|=> ##1 page_unlocked_o) else $error("page port stayed locked");
	lock_ign_a:
		assert property (hit_pg && !page_unlocked_o && $past(io_write_strobe_n_i)
			|=> rom_enable_n_o [*6]) else $error("locked write gave strobe");
	page_pls_a:
		assert property (hit_pg && page_unlocked_o && $past(io_write_strobe_n_i)
			|=> rom_enable_n_o ##1 !rom_enable_n_o [*5] ##1 rom_enable_n_o)
		else $error("page strobe not five cycles low");
	done_a:
		assert property (local_mode_i && cycle_start_i && !local_bus_reset_i &&
			!host_ready_in_n_i |=> cycle_done_o) else $error("no cycle done");
	no_tick_a:
		assert property (!power_down_control_reg_i[6] [*6] |-> !refresh_tick_o)
		else $error("refresh tick while unselected");
endmodule
bind hbcd_top hbcd_chk u_chk (.*);
`default_nettype wire

/* File: hbcd_defines.svh */
// Purpose: Constants for the host bus cycle decode block
// Assumes: 250 MHz core clock
// Notes:   Offsets, masks and counts only; no logic
`ifndef HBCD_DEFINES_SVH
`define HBCD_DEFINES_SVH

`define HBCD_ROM_BASE        24'hC_0000
`define HBCD_ROM_LAST        24'hC_7FFF
`define HBCD_PAGE_PORT       16'h46E8
`define HBCD_UNLOCK_PORT     16'hA875
`define HBCD_UNLOCK_VALUE    8'hAC
`define HBCD_ROM_CTL_EN_BIT  0
`define HBCD_PD_LOWREF_BIT   6
`define HBCD_STRAP_RESET     16'h0000
`define HBCD_CLK_PERIOD_NS   4
// Width of the page-register write strobe, in ns and in cycles
`define HBCD_STROBE_NS       20
`define HBCD_STROBE_CYC      ((`HBCD_STROBE_NS + `HBCD_CLK_PERIOD_NS - 1) / `HBCD_CLK_PERIOD_NS)

`endif

/* File: hbcd_host.sv */
// Purpose: Host bus model for hbcd_top
// Assumes: Drives 1 ns after the rising edge
// Notes:   Slow clock moves only on request
`timescale 1ns/100ps
`default_nettype none
module hbcd_host (
	// Clock
	input  wire logic        clk_i,
	// Strobes and handshake
	output var  logic        mem_read_strobe_n_o,
	output var  logic        mem_write_strobe_n_o,
	output var  logic        refresh_n_o,
	output var  logic        io_read_strobe_n_o,
	output var  logic        io_write_strobe_n_o,
	output var  logic        host_ready_in_n_o,
	output var  logic        cycle_start_o,
	output var  logic        low_rate_refresh_clk_o,
	// Address and data
	output var  logic [23:0] mem_addr_o,
	output var  logic [15:0] io_addr_o,
	output var  logic [7:0]  io_wdata_o
);
	logic [4:0] stb = 5'h1F;
	// Strobe pins from one vector; idle keeps refresh off for accesses
	assign {mem_read_strobe_n_o, mem_write_strobe_n_o, refresh_n_o,
		io_read_strobe_n_o, io_write_strobe_n_o} = stb;
	// Idle bus at time zero
	initial begin
		{host_ready_in_n_o, cycle_start_o, low_rate_refresh_clk_o} = 3'h4;
		mem_addr_o = 24'h00_0000;
		io_addr_o = 16'h0000;
		io_wdata_o = 8'h00;
	end
	// One-cycle expansion access, n gives the five strobe levels
	task automatic exp_cyc(input logic [4:0] n, input logic [23:0] ma,
		input logic [15:0] ia, input logic [7:0] d);
		@(posedge clk_i) #1;
		stb = n;
		mem_addr_o = ma;
		io_addr_o = ia;
		io_wdata_o = d;
		@(posedge clk_i) #1;
		stb = 5'h1F;
		io_wdata_o = ~d; // Released data must not look still valid
	endtask
	// Local cycle, M/IO and W/R on the memory strobe pins, ready after wt
	task automatic loc_cyc(input logic mio, input logic wr, input int wt);
		@(posedge clk_i) #1;
		cycle_start_o = 1'b1;
		stb[4:3] = {mio, wr};
		repeat (wt) @(posedge clk_i);
		#1 host_ready_in_n_o = 1'b0;
		@(posedge clk_i) #1;
		{host_ready_in_n_o, cycle_start_o} = 2'h2;
		stb[4:3] = 2'h3;
	endtask
	// Slow clock edge, set at once when called, with no wait for a clock edge
	task automatic slow_set(input logic v);
		low_rate_refresh_clk_o = v;
	endtask
endmodule
`default_nettype wire

/* File: hbcd_pkg.sv */
// Purpose: Types for the host bus cycle decode block
// Assumes: Nothing beyond the defines header
// Notes:   Holds enumerations only
package hbcd_pkg;

	// Bus personality of the shared pins
	typedef enum logic {
		HBCD_BUS_EXP   = 1'b0,
		HBCD_BUS_LOCAL = 1'b1
	} hbcd_mode_t;

	// Qualified cycle type
	typedef enum logic [2:0] {
		HBCD_CYC_IDLE  = 3'b000,
		HBCD_CYC_MEMRD = 3'b001,
		HBCD_CYC_MEMWR = 3'b010,
		HBCD_CYC_IORD  = 3'b011,
		HBCD_CYC_IOWR  = 3'b100,
		HBCD_CYC_REFR  = 3'b101
	} hbcd_cycle_t;

	// Page strobe sequencer
	typedef enum logic [1:0] {
		HBCD_ST_LOCKED = 2'b00,
		HBCD_ST_OPEN   = 2'b01,
		HBCD_ST_PULSE  = 2'b10
	} hbcd_state_t;

endpackage

/* File: hbcd_sync.sv */
// Purpose: Two-flop synchroniser for an asynchronous level
// Assumes: Destination clock is clk_i
// Notes:   First flop feeds only the second
`timescale 1ns/100ps
`default_nettype none

module hbcd_sync (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	// Level in and out
	input  wire logic d_i,
	output var  logic q_o
);

	logic meta_q;

	// Two stages; meta_q is read by q_o only
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_q <= 1'b0;
			q_o    <= 1'b0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end

endmodule
`default_nettype wire

/* File: hbcd_top.sv */
// Purpose: Qualify host cycles on expansion or local bus, drive ROM enable
// Assumes: Host pins synchronous to clk_i; low-rate clock is asynchronous
// Notes:   Registers reached only as ports; address and data paths elsewhere
`timescale 1ns/100ps
`default_nettype none
`include "hbcd_defines.svh"

// Summary of operation
// - Expansion memory strobes count only while refresh is inactive.
// - Local bus write-or-read high means write, low means read.
// - Strap bits load from memory bus levels at power-up reset.
// - Local bus reset clears local logic and reloads straps.
// - Active refresh on expansion bus starts a buffer refresh.
// - ROM enable asserts for C0000h-C7FFFh only when ROM control bit 0 set.
// - Write to port 46E8h pulses ROM enable as page register strobe.
// - Port 46E8h writes ignored until ACh written to port A875h.
// - Local bus mode uses low-rate clock as refresh timebase in power-down.
// - Low-rate clock selected only when power-down bit 6 is one.
// - Local bus cycles complete in step with host ready-in.
module hbcd_top (
	// Clock and resets
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        local_bus_reset_i,
	// Configuration
	input  wire logic        local_mode_i,
	input  wire logic [7:0]  rom_control_reg_i,
	input  wire logic [7:0]  power_down_control_reg_i,
	input  wire logic        power_down_i,
	input  wire logic [15:0] mem_bus_strap_i,
	// Shared bus pins
	input  wire logic        mem_read_strobe_n_i,
	input  wire logic        mem_write_strobe_n_i,
	input  wire logic        refresh_n_i,
	input  wire logic        io_read_strobe_n_i,
	input  wire logic        io_write_strobe_n_i,
	input  wire logic        host_ready_in_n_i,
	input  wire logic        cycle_start_i,
	input  wire logic        low_rate_refresh_clk_i,
	// Address and write data seen by the decode
	input  wire logic [23:0] mem_addr_i,
	input  wire logic [15:0] io_addr_i,
	input  wire logic [7:0]  io_wdata_i,
	// Decode results
	output var  logic [2:0]  cycle_type_o,
	output var  logic        mem_access_o,
	output var  logic        refresh_start_o,
	output var  logic        refresh_tick_o,
	output var  logic        cycle_done_o,
	output var  logic        rom_enable_n_o,
	output var  logic        page_unlocked_o,
	output var  logic [15:0] strap_o
);

	localparam int STROBE_CYC = `HBCD_STROBE_CYC;

	hbcd_pkg::hbcd_mode_t  mode;
	hbcd_pkg::hbcd_cycle_t cyc_d;
	hbcd_pkg::hbcd_state_t st_q;
	logic [3:0]            pulse_cnt_q;
	logic                  lb_reset_q;
	logic                  strap_load_q;
	logic                  exp_mem_rd;
	logic                  exp_mem_wr;
	logic                  exp_io_rd;
	logic                  exp_io_wr;
	logic                  lb_mem;
	logic                  lb_wr;
	logic                  io_wr;
	logic                  mem_any;
	logic                  rom_hit;
	logic                  refr_active;
	logic                  refr_prev_q;
	logic                  lowclk_s;
	logic                  lowclk_prev_q;
	logic                  use_low;
	logic                  lb_busy_q;
	logic                  rom_strobe;

	// Shared pins take exactly one meaning, chosen by the mode strap
	assign mode = local_mode_i ? hbcd_pkg::HBCD_BUS_LOCAL
	                           : hbcd_pkg::HBCD_BUS_EXP;

	// Expansion strobes; memory ones are masked by refresh
	assign refr_active = (mode == hbcd_pkg::HBCD_BUS_EXP) && !refresh_n_i;
	assign exp_mem_rd  = !mem_read_strobe_n_i && !refr_active;
	assign exp_mem_wr  = !mem_write_strobe_n_i && !refr_active;
	assign exp_io_rd   = !io_read_strobe_n_i;
	assign exp_io_wr   = !io_write_strobe_n_i;

	// Local bus reuses the memory strobe pins as M/IO and W/R
	assign lb_mem = mem_read_strobe_n_i;
	assign lb_wr  = mem_write_strobe_n_i;

	// Cycle decode per bus personality
	always_comb begin
		cyc_d = hbcd_pkg::HBCD_CYC_IDLE;
		if (mode == hbcd_pkg::HBCD_BUS_EXP) begin
			if (refr_active) begin
				cyc_d = hbcd_pkg::HBCD_CYC_REFR;
			end else if (exp_mem_rd) begin
				cyc_d = hbcd_pkg::HBCD_CYC_MEMRD;
			end else if (exp_mem_wr) begin
				cyc_d = hbcd_pkg::HBCD_CYC_MEMWR;
			end else if (exp_io_rd) begin
				cyc_d = hbcd_pkg::HBCD_CYC_IORD;
			end else if (exp_io_wr) begin
				cyc_d = hbcd_pkg::HBCD_CYC_IOWR;
			end
		end else if (cycle_start_i && !lb_reset_q) begin
			case ({lb_mem, lb_wr})
				2'b00:   cyc_d = hbcd_pkg::HBCD_CYC_IORD;
				2'b01:   cyc_d = hbcd_pkg::HBCD_CYC_IOWR;
				2'b10:   cyc_d = hbcd_pkg::HBCD_CYC_MEMRD;
				2'b11:   cyc_d = hbcd_pkg::HBCD_CYC_MEMWR;
				default: cyc_d = hbcd_pkg::HBCD_CYC_IDLE;
			endcase
		end
	end

	assign mem_any = (cyc_d == hbcd_pkg::HBCD_CYC_MEMRD) ||
	                 (cyc_d == hbcd_pkg::HBCD_CYC_MEMWR);
	assign io_wr   = (cyc_d == hbcd_pkg::HBCD_CYC_IOWR);
	assign rom_hit = rom_control_reg_i[`HBCD_ROM_CTL_EN_BIT] &&
	                 (cyc_d == hbcd_pkg::HBCD_CYC_MEMRD) &&
	                 (mem_addr_i >= `HBCD_ROM_BASE) &&
	                 (mem_addr_i <= `HBCD_ROM_LAST);

	// Registered decode outputs
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cycle_type_o <= 3'h0;
			mem_access_o <= 1'b0;
		end else begin
			cycle_type_o <= cyc_d;
			mem_access_o <= mem_any;
		end
	end

	// Refresh start: one pulse on the falling edge of refresh
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			refr_prev_q     <= 1'b0;
			refresh_start_o <= 1'b0;
		end else begin
			refr_prev_q     <= refr_active;
			refresh_start_o <= refr_active && !refr_prev_q;
		end
	end

	// Low-rate clock is asynchronous, so it is brought in through flops
	hbcd_sync u_lowclk_sync (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.d_i     (low_rate_refresh_clk_i),
		.q_o     (lowclk_s)
	);

	// Refresh timebase swaps to the slow clock only in local power-down
	assign use_low = (mode == hbcd_pkg::HBCD_BUS_LOCAL) && power_down_i &&
	                 power_down_control_reg_i[`HBCD_PD_LOWREF_BIT];

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lowclk_prev_q  <= 1'b0;
			refresh_tick_o <= 1'b0;
		end else begin
			lowclk_prev_q  <= lowclk_s;
			refresh_tick_o <= use_low && lowclk_s && !lowclk_prev_q;
		end
	end

	// Local bus reset is held one cycle registered for a clean release
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lb_reset_q <= 1'b1;
		end else begin
			lb_reset_q <= local_bus_reset_i && local_mode_i;
		end
	end

	// Straps: caught on the first clock after either reset releases
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			strap_load_q <= 1'b1;
			strap_o      <= `HBCD_STRAP_RESET;
		end else begin
			strap_load_q <= lb_reset_q;
			if (strap_load_q || lb_reset_q) begin
				strap_o <= mem_bus_strap_i;
			end
		end
	end

	// Local cycle is busy from start until host ready-in samples low
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lb_busy_q    <= 1'b0;
			cycle_done_o <= 1'b0;
		end else if (lb_reset_q) begin
			lb_busy_q    <= 1'b0;
			cycle_done_o <= 1'b0;
		end else begin
			cycle_done_o <= 1'b0;
			if (cyc_d != hbcd_pkg::HBCD_CYC_IDLE &&
			    mode == hbcd_pkg::HBCD_BUS_LOCAL) begin
				lb_busy_q <= 1'b1;
			end
			if ((lb_busy_q || cycle_start_i) && !host_ready_in_n_i) begin
				lb_busy_q    <= 1'b0;
				cycle_done_o <= 1'b1;
			end
		end
	end

	// Unlock and page-strobe sequencer; unlock holds until another value is written to port A875h
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q        <= hbcd_pkg::HBCD_ST_LOCKED;
			pulse_cnt_q <= 4'h0;
		end else begin
			case (st_q)
				hbcd_pkg::HBCD_ST_LOCKED: begin
					if (io_wr && io_addr_i == `HBCD_UNLOCK_PORT &&
					    io_wdata_i == `HBCD_UNLOCK_VALUE) begin
						st_q <= hbcd_pkg::HBCD_ST_OPEN;
					end
				end
				hbcd_pkg::HBCD_ST_OPEN: begin
					if (io_wr && io_addr_i == `HBCD_PAGE_PORT) begin
						st_q        <= hbcd_pkg::HBCD_ST_PULSE;
						pulse_cnt_q <= 4'(STROBE_CYC - 1);
					end else if (io_wr && io_addr_i == `HBCD_UNLOCK_PORT &&
					             io_wdata_i != `HBCD_UNLOCK_VALUE) begin
						st_q <= hbcd_pkg::HBCD_ST_LOCKED;
					end
				end
				hbcd_pkg::HBCD_ST_PULSE: begin
					if (pulse_cnt_q == 4'h0) begin
						st_q <= hbcd_pkg::HBCD_ST_OPEN;
					end else begin
						pulse_cnt_q <= pulse_cnt_q - 4'h1;
					end
				end
				default: st_q <= hbcd_pkg::HBCD_ST_LOCKED;
			endcase
		end
	end

	assign rom_strobe = (st_q == hbcd_pkg::HBCD_ST_PULSE);

	// ROM enable: ROM window read or page strobe, expansion mode only
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rom_enable_n_o  <= 1'b1;
			page_unlocked_o <= 1'b0;
		end else begin
			rom_enable_n_o  <= !((rom_hit || rom_strobe) &&
			                    mode == hbcd_pkg::HBCD_BUS_EXP);
			page_unlocked_o <= (st_q != hbcd_pkg::HBCD_ST_LOCKED);
		end
	end

endmodule
`default_nettype wire

/* File: tb_top.sv */
// Purpose: Self-checking bench for hbcd_top
// Assumes: 250 MHz clock, host model drives the bus pins
// Notes:   One task per scenario
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	// Configuration driven by the bench
	logic clk_i = 1'b0, rst_b_i = 1'b0, local_bus_reset_i = 1'b0;
	logic local_mode_i = 1'b0, power_down_i = 1'b0;
	logic [7:0] rom_control_reg_i = 8'h00, power_down_control_reg_i = 8'h00;
	logic [15:0] mem_bus_strap_i = 16'h3C5A;
	// Host pins and results
	logic mem_read_strobe_n_i, mem_write_strobe_n_i, refresh_n_i;
	logic io_read_strobe_n_i, io_write_strobe_n_i, host_ready_in_n_i;
	logic cycle_start_i, low_rate_refresh_clk_i, seen;
	logic [23:0] mem_addr_i;
	logic [15:0] io_addr_i, strap_o;
	logic [7:0] io_wdata_i;
	logic [2:0] cycle_type_o;
	logic mem_access_o, refresh_start_o, refresh_tick_o, cycle_done_o;
	logic rom_enable_n_o, page_unlocked_o;
	int num_errors = 0, comparisons = 0;
	hbcd_top dut (.*);
	hbcd_host host (.clk_i, .mem_read_strobe_n_o(mem_read_strobe_n_i),
		.mem_write_strobe_n_o(mem_write_strobe_n_i), .refresh_n_o(refresh_n_i),
		.io_read_strobe_n_o(io_read_strobe_n_i), .cycle_start_o(cycle_start_i),
		.io_write_strobe_n_o(io_write_strobe_n_i), .mem_addr_o(mem_addr_i),
		.host_ready_in_n_o(host_ready_in_n_i), .io_addr_o(io_addr_i),
		.low_rate_refresh_clk_o(low_rate_refresh_clk_i), .io_wdata_o(io_wdata_i));
	// Clock
	always #2 clk_i = ~clk_i;
	task automatic step();
		@(posedge clk_i) #1;
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Reads in and out of the ROM window, a write, and refresh overlap
	task automatic t_exp();
		rom_control_reg_i = 8'h01;
		host.exp_cyc(5'h0F, 24'hC_7FFF, 16'h0000, 8'h00);
		chk({cycle_type_o, mem_access_o, rom_enable_n_o}, 24'h6);
		host.exp_cyc(5'h0F, 24'hC_8000, 16'h0000, 8'h00);
		chk(rom_enable_n_o, 24'h1);
		rom_control_reg_i = 8'h00;
		host.exp_cyc(5'h0F, 24'hC_0000, 16'h0000, 8'h00);
		chk(rom_enable_n_o, 24'h1);
		host.exp_cyc(5'h17, 24'hC_0000, 16'h0000, 8'h00);
		chk(cycle_type_o, 24'h2);
		host.exp_cyc(5'h0B, 24'hC_0000, 16'h0000, 8'h00);
		chk({mem_access_o, refresh_start_o}, 24'h1);
	endtask
	// Locked write, unlock, five-cycle strobe, relock by another value
	task automatic t_page();
		host.exp_cyc(5'h1E, 24'h00_0000, 16'h46E8, 8'h01);
		repeat (7) begin
			chk(rom_enable_n_o, 24'h1);
			step();
		end
		host.exp_cyc(5'h1E, 24'h00_0000, 16'hA875, 8'hAC);
		step();
		chk(page_unlocked_o, 24'h1);
		host.exp_cyc(5'h1E, 24'h00_0000, 16'h46E8, 8'h5A);
		for (int i = 0; i < 7; i++) begin
			chk(rom_enable_n_o, {23'h0, i == 0 || i == 6});
			step();
		end
		host.exp_cyc(5'h1E, 24'h00_0000, 16'hA875, 8'hAB);
		step();
		chk(page_unlocked_o, 24'h0);
	endtask
	// All four local cycle kinds, prompt and slow ready, ROM kept off
	task automatic t_local();
		local_mode_i = 1'b1;
		rom_control_reg_i = 8'h01;
		for (int i = 0; i < 4; i++) begin
			host.loc_cyc(i[1], i[0], 3 * i[0]);
			// Expected: I/O read 3, I/O write 4, memory read 1, memory write 2
			chk(cycle_type_o, (i < 2) ? 3 + i : i - 1);
			chk({cycle_done_o, rom_enable_n_o}, 24'h3);
		end
	endtask
	// Local reset reloads straps; slow clock only when selected
	task automatic t_misc();
		mem_bus_strap_i = 16'hA5C3;
		local_bus_reset_i = 1'b1;
		repeat (4) step();
		local_bus_reset_i = 1'b0;
		step();
		chk(strap_o, 24'h00_A5C3);
		power_down_i = 1'b1;
		for (int k = 1; k >= 0; k--) begin
			power_down_control_reg_i = {1'b0, k[0], 6'h00};
			host.slow_set(1'b1);
			seen = 1'b0;
			repeat (12) begin
				step();
				seen |= refresh_tick_o;
			end
			chk(seen, k);
			host.slow_set(1'b0);
			repeat (4) step();
		end
	endtask
	// Main sequence; reset held 16 cycles with the clock running
	initial begin
		repeat (16) step();
		rst_b_i = 1'b1;
		repeat (2) step();
		chk(strap_o, 24'h00_3C5A);
		t_exp();
		t_page();
		t_local();
		t_misc();
		complete_run();
	end
	// Watchdog, far beyond the hundred or so cycles the run needs
	initial begin
		#40000 num_errors++;
		complete_run();
	end
endmodule
`default_nettype wire
